// ===== design/hgc_pkg.sv
// Purpose: Constants shared by the hub general config/status block
// Assumes: Byte-wide register port, 200 MHz core clock
// Notes  : Reference clock pin is sampled as a synchronous input
//
// Operation
// - The I2C controller runs only while its enable bit is 1, reset 0.
// - Lockless select 0 and no assigned port locked gives high impedance.
// - Lockless select 1 (reset) keeps running; no lock gives LP-11 when idle select and drive enable are both 1.
// - In continue mode lock still governs unless idle select 1 and drive enable 0: lock gives normal output, no lock the idle state.
// - Idle select 1 and drive enable 0 give high impedance; both reset 1.
// - Idle select 0 with lock low and lockless select 1 forces the transmitter into HS-0.
// - Receiver parity checking runs only while its enable is 1, reset 1.
// - Override 0 takes presence from the detector, 1 forces it present.
// - Clock-valid status is 1 only for a reference of 12 MHz to 64 MHz.
// - After initialization the checksum status shows if data was valid.
// - The init-done status sets once configuration loading has completed.
// - The revision register holds silicon revision high and mask low.
// - Reload bit self-clears and restarts loading; poll init-done after.
`default_nettype none
package hgc_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_RESET_CTL  = 8'h01;
   localparam logic [7:0] ADDR_GEN_CFG    = 8'h02;
   localparam logic [7:0] ADDR_REV_ID     = 8'h03;
   localparam logic [7:0] ADDR_DEV_STATUS = 8'h04;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_RELOAD       = 2;
   localparam int BIT_I2C_EN       = 5;
   localparam int BIT_LOCKLESS_SEL = 4;
   localparam int BIT_DRIVE_EN     = 3;
   localparam int BIT_IDLE_SEL     = 2;
   localparam int BIT_PARITY_EN    = 1;
   localparam int BIT_REF_OVERRIDE = 0;
   localparam int BIT_CKSUM_OK     = 7;
   localparam int BIT_INIT_DONE    = 6;
   localparam int BIT_REF_FREQ_OK  = 4;

   // Reset value of the writable bits of the general configuration register
   localparam logic [5:0] GEN_CFG_RESET = 6'h1E;

   // Identification, values arbitrary
   localparam logic [3:0] SILICON_REVISION = 4'h1;
   localparam logic [3:0] MASK_REVISION    = 4'h5;

   // ----------------------------------------
   // Transmitter output state
   // ----------------------------------------
   localparam logic [1:0] TX_NORMAL = 2'h0;
   localparam logic [1:0] TX_HIZ    = 2'h1;
   localparam logic [1:0] TX_LP11   = 2'h2;
   localparam logic [1:0] TX_HS0    = 2'h3;

   // ----------------------------------------
   // Reference clock measurement
   // ----------------------------------------
   localparam int CLK_MHZ      = 200;
   localparam int WINDOW_NS    = 1000;
   localparam int WINDOW_CYC   = WINDOW_NS * CLK_MHZ / 1000;
   localparam int REF_MIN_MHZ  = 12;
   localparam int REF_MAX_MHZ  = 64;
   // Edges counted per window equal the frequency in MHz
   localparam logic [7:0] WINDOW_LAST = 8'(WINDOW_CYC - 1);
   localparam logic [7:0] EDGE_MIN = 8'(REF_MIN_MHZ * WINDOW_NS / 1000);
   localparam logic [7:0] EDGE_MAX = 8'(REF_MAX_MHZ * WINDOW_NS / 1000);
   localparam logic [7:0] EDGE_SAT = 8'hFF;

   // ----------------------------------------
   // Loader states
   // ----------------------------------------
   typedef enum logic [2:0] {
      LD_START = 3'b001,
      LD_WAIT  = 3'b010,
      LD_DONE  = 3'b100
   } hgc_load_type;

endpackage
`default_nettype wire

// ===== design/hgc_ref_freq_check.sv
// Purpose: Measures reference clock frequency against the valid band
// Assumes: Reference pin sampled synchronously, below half the core rate
// Notes  : Result updates once per measurement window
`timescale 1ns/1ps
`default_nettype none
module hgc_ref_freq_check
   import hgc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Reference pin
   input  wire logic ref_in,
   // Result
   output logic      freq_ok
);

   typedef struct packed {
      logic       prev;
      logic [7:0] win_cnt;
      logic [7:0] edge_cnt;
      logic       ok;
   } hgc_freq_state_type;

   hgc_freq_state_type s_reg;
   hgc_freq_state_type s_next;

   // ----------------------------------------
   // Edge counting
   // ----------------------------------------
   always_comb begin
      s_next      = s_reg;
      s_next.prev = ref_in;
      if (s_reg.win_cnt == WINDOW_LAST) begin
         s_next.win_cnt  = 8'h00;
         s_next.edge_cnt = 8'h00;
         s_next.ok = (s_reg.edge_cnt >= EDGE_MIN) &&
                     (s_reg.edge_cnt <= EDGE_MAX);
      end else begin
         s_next.win_cnt = s_reg.win_cnt + 8'h01;
         if (ref_in && !s_reg.prev && s_reg.edge_cnt != EDGE_SAT) begin
            s_next.edge_cnt = s_reg.edge_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign freq_ok = s_reg.ok;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_FREQ_BAND: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.win_cnt == WINDOW_LAST) |=>
         (freq_ok == ($past(s_reg.edge_cnt) >= EDGE_MIN &&
                      $past(s_reg.edge_cnt) <= EDGE_MAX)))
      else $error("Reference valid flag disagrees with edge count");

endmodule
`default_nettype wire

// ===== design/hgc_top.sv
// Purpose: Shared general configuration and status registers of the hub
// Assumes: Single-cycle register strobes, read data one cycle later
// Notes  : Outputs all come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module hgc_top
   import hgc_pkg::*;
(
   // Clock and reset
   input  wire logic       CORE_CLK,
   input  wire logic       NRST,
   // Register port
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_WR_STB,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_RD_STB,
   output logic      [7:0] REG_RDATA,
   // Receiver lock and transmitter assignment
   input  wire logic [3:0] RX_LOCK,
   input  wire logic [3:0] RX_PORT_ASSIGN,
   // Reference clock pin
   input  wire logic       REFERENCE_CLOCK_INPUT,
   // Configuration store handshake
   input  wire logic       CFG_LOAD_DONE,
   input  wire logic       CFG_LOAD_CKSUM_OK,
   output logic            CFG_LOAD_START,
   // Controls to the rest of the device
   output logic            I2C_CTRL_EN,
   output logic      [1:0] TX_OUT_STATE,
   output logic            PARITY_CHECK_EN,
   output logic            REF_CLOCK_PRESENT
);

   typedef struct packed {
      logic [5:0]   cfg;
      hgc_load_type ld;
      logic         init_done;
      logic         cksum_ok;
      logic         load_start;
      logic [7:0]   rdata;
      logic         i2c_en;
      logic [1:0]   tx_state;
      logic         parity_en;
      logic         ref_present;
   } hgc_state_type;

   hgc_state_type s_reg;
   hgc_state_type s_next;
   logic          freq_ok;
   logic          wr_gen;
   logic          wr_reload;
   logic          any_lock;

   hgc_ref_freq_check u_freq (
      .clk     (CORE_CLK),
      .nrst    (NRST),
      .ref_in  (REFERENCE_CLOCK_INPUT),
      .freq_ok (freq_ok)
   );

   assign wr_gen    = REG_WR_STB && (REG_ADDR == ADDR_GEN_CFG);
   assign wr_reload = REG_WR_STB && (REG_ADDR == ADDR_RESET_CTL) &&
                      REG_WDATA[BIT_RELOAD];
   assign any_lock  = |(RX_LOCK & RX_PORT_ASSIGN);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;

      if (wr_gen) begin
         s_next.cfg = REG_WDATA[5:0];
      end

      // Configuration loader
      s_next.load_start = 1'b0;
      unique case (s_reg.ld)
         LD_START: begin
            s_next.load_start = 1'b1;
            s_next.ld         = LD_WAIT;
         end
         LD_WAIT: begin
            if (CFG_LOAD_DONE) begin
               s_next.ld        = LD_DONE;
               s_next.init_done = 1'b1;
               s_next.cksum_ok  = CFG_LOAD_CKSUM_OK;
            end
         end
         LD_DONE: begin
         end
      endcase
      if (wr_reload) begin
         s_next.ld        = LD_START;
         s_next.init_done = 1'b0;
         s_next.cksum_ok  = 1'b0;
      end

      s_next.i2c_en    = s_next.cfg[BIT_I2C_EN];
      s_next.parity_en = s_next.cfg[BIT_PARITY_EN];
      s_next.ref_present = s_next.cfg[BIT_REF_OVERRIDE] | freq_ok;

      // Drive-off and lockless high impedance win over the idle states
      if (s_next.cfg[BIT_IDLE_SEL] && !s_next.cfg[BIT_DRIVE_EN]) begin
         s_next.tx_state = TX_HIZ;
      end else if (!any_lock && !s_next.cfg[BIT_LOCKLESS_SEL]) begin
         s_next.tx_state = TX_HIZ;
      end else if (!any_lock && !s_next.cfg[BIT_IDLE_SEL]) begin
         s_next.tx_state = TX_HS0;
      end else if (!any_lock) begin
         s_next.tx_state = TX_LP11;
      end else begin
         s_next.tx_state = TX_NORMAL;
      end

      // Read data, unmapped and reserved bits read zero
      if (REG_RD_STB) begin
         s_next.rdata = 8'h00;
         unique case (REG_ADDR)
            ADDR_GEN_CFG: begin
               s_next.rdata[5:0] = s_reg.cfg;
            end
            ADDR_REV_ID: begin
               s_next.rdata = {SILICON_REVISION, MASK_REVISION};
            end
            ADDR_DEV_STATUS: begin
               s_next.rdata[BIT_CKSUM_OK]    = s_reg.cksum_ok;
               s_next.rdata[BIT_INIT_DONE]   = s_reg.init_done;
               s_next.rdata[BIT_REF_FREQ_OK] = freq_ok;
            end
            default: begin
               // Reload bit self-clears, so it reads zero
               s_next.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         s_reg             <= '0;
         s_reg.cfg         <= GEN_CFG_RESET;
         s_reg.ld          <= LD_START;
         s_reg.parity_en   <= 1'b1;
         s_reg.tx_state    <= TX_HIZ;
      end else begin
         s_reg <= s_next;
      end
   end

   assign REG_RDATA         = s_reg.rdata;
   assign CFG_LOAD_START    = s_reg.load_start;
   assign I2C_CTRL_EN       = s_reg.i2c_en;
   assign TX_OUT_STATE      = s_reg.tx_state;
   assign PARITY_CHECK_EN   = s_reg.parity_en;
   assign REF_CLOCK_PRESENT = s_reg.ref_present;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   AST_I2C_ENABLE: assert property (
      wr_gen |=> (I2C_CTRL_EN == $past(REG_WDATA[BIT_I2C_EN])))
      else $error("I2C enable does not follow written bit");

   AST_LOCKLESS_HIZ: assert property (
      (!wr_gen && !any_lock && !s_reg.cfg[BIT_LOCKLESS_SEL])
         |=> (TX_OUT_STATE == TX_HIZ))
      else $error("No high impedance without lock");

   AST_LOCKLESS_LP11: assert property (
      (!wr_gen && !any_lock && s_reg.cfg[5:2] != 4'h0 &&
       s_reg.cfg[BIT_LOCKLESS_SEL] && s_reg.cfg[BIT_IDLE_SEL] &&
       s_reg.cfg[BIT_DRIVE_EN]) |=> (TX_OUT_STATE == TX_LP11))
      else $error("No LP-11 without lock in continue mode");

   AST_LOCKED_NORMAL: assert property (
      (!wr_gen && any_lock && s_reg.cfg[BIT_LOCKLESS_SEL] &&
       !(s_reg.cfg[BIT_IDLE_SEL] && !s_reg.cfg[BIT_DRIVE_EN]))
         |=> (TX_OUT_STATE == TX_NORMAL))
      else $error("Transmitter overridden while locked");

   AST_DRIVE_OFF: assert property (
      (!wr_gen && s_reg.cfg[BIT_IDLE_SEL] && !s_reg.cfg[BIT_DRIVE_EN])
         |=> (TX_OUT_STATE == TX_HIZ))
      else $error("Drive disable did not force high impedance");

   AST_IDLE_HS0: assert property (
      (!wr_gen && !any_lock && !s_reg.cfg[BIT_IDLE_SEL] &&
       s_reg.cfg[BIT_LOCKLESS_SEL]) |=> (TX_OUT_STATE == TX_HS0))
      else $error("No HS-0 with idle select low");

   AST_PARITY_EN: assert property (
      wr_gen |=> (PARITY_CHECK_EN == $past(REG_WDATA[BIT_PARITY_EN])))
      else $error("Parity enable does not follow written bit");

   AST_REF_PRESENT: assert property (
      !wr_gen |=> (REF_CLOCK_PRESENT ==
                   ($past(s_reg.cfg[BIT_REF_OVERRIDE]) | $past(freq_ok))))
      else $error("Reference presence wrong");

   AST_LOAD_RESULT: assert property (
      (s_reg.ld == LD_WAIT && CFG_LOAD_DONE && !wr_reload)
         |=> (s_reg.init_done && s_reg.cksum_ok == $past(CFG_LOAD_CKSUM_OK)))
      else $error("Load result not captured");

   AST_RELOAD: assert property (
      wr_reload |=> (!s_reg.init_done ##1 CFG_LOAD_START))
      else $error("Reload did not restart loading");

   AST_INIT_HOLD: assert property (
      (s_reg.init_done && !wr_reload) |=> s_reg.init_done)
      else $error("Init done dropped without reload");

   AST_REV_READ: assert property (
      (REG_RD_STB && REG_ADDR == ADDR_REV_ID)
         |=> (REG_RDATA == {SILICON_REVISION, MASK_REVISION}))
      else $error("Revision register read wrong");

   AST_RESERVED_ZERO: assert property (
      (REG_RD_STB && REG_ADDR == ADDR_DEV_STATUS)
         |=> (REG_RDATA[5] == 1'b0 && REG_RDATA[3:0] == 4'h0))
      else $error("Reserved status bits not zero");

   AST_CFG_WRITE: assert property (
      wr_gen |=> (s_reg.cfg == $past(REG_WDATA[5:0])))
      else $error("Configuration write not stored");

   AST_CFG_STABLE: assert property (
      !wr_gen |=> (s_reg.cfg == $past(s_reg.cfg)))
      else $error("Configuration changed without a write");

   AST_CFG_READ: assert property (
      (REG_RD_STB && REG_ADDR == ADDR_GEN_CFG)
         |=> (REG_RDATA == {2'b00, $past(s_reg.cfg)}))
      else $error("General configuration read wrong");

   AST_STATUS_READ: assert property (
      (REG_RD_STB && REG_ADDR == ADDR_DEV_STATUS)
         |=> (REG_RDATA[BIT_INIT_DONE] == $past(s_reg.init_done) &&
              REG_RDATA[BIT_CKSUM_OK] == $past(s_reg.cksum_ok)))
      else $error("Status read does not show the load result");

   AST_FREQ_READ: assert property (
      (REG_RD_STB && REG_ADDR == ADDR_DEV_STATUS)
         |=> (REG_RDATA[BIT_REF_FREQ_OK] == $past(freq_ok)))
      else $error("Status read does not show the reference check");

   AST_UNMAPPED_ZERO: assert property (
      (REG_RD_STB && REG_ADDR != ADDR_GEN_CFG && REG_ADDR != ADDR_REV_ID &&
       REG_ADDR != ADDR_DEV_STATUS) |=> (REG_RDATA == 8'h00))
      else $error("Unmapped or reload address did not read zero");

   AST_RDATA_HOLD: assert property (
      !REG_RD_STB |=> (REG_RDATA == $past(REG_RDATA)))
      else $error("Read data changed without a read");

   AST_START_IDLE: assert property (
      (s_reg.ld == LD_WAIT) |=> !CFG_LOAD_START)
      else $error("Load start raised while waiting");

   AST_INIT_RISE: assert property (
      $rose(s_reg.init_done) |-> $past(CFG_LOAD_DONE))
      else $error("Init done set without a load answer");

   AST_DONE_IGNORED: assert property (
      (s_reg.ld == LD_DONE && !wr_reload)
         |=> (s_reg.init_done == $past(s_reg.init_done) &&
              s_reg.cksum_ok == $past(s_reg.cksum_ok)))
      else $error("Load result changed outside the wait state");

   AST_CKSUM_CLEARED: assert property (
      wr_reload |=> !s_reg.cksum_ok)
      else $error("Checksum status kept over a reload");

   AST_RELOAD_WINS: assert property (
      (s_reg.ld == LD_WAIT && CFG_LOAD_DONE && wr_reload)
         |=> !s_reg.init_done)
      else $error("Load answer won over a reload request");

   // ----------------------------------------
   // Scenario covers
   // ----------------------------------------
   COV_RELOAD: cover property (wr_reload ##[1:20] CFG_LOAD_DONE);
   COV_LP11: cover property (TX_OUT_STATE == TX_LP11);
   COV_HS0: cover property (TX_OUT_STATE == TX_HS0);
   COV_FREQ_OK: cover property (freq_ok);
   COV_LOCKED: cover property (TX_OUT_STATE == TX_NORMAL);

endmodule
`default_nettype wire

// ===== sim/hgc_store_model.sv
// Purpose: Configuration store and reference clock source beside the hub
// Assumes: Store answers a load request after a fixed short delay
// Notes  : Checksum line toggles once the done pulse is over
`timescale 1ns/1ps
`default_nettype none
module hgc_store_model (
   // Clock
   input  wire logic clk,
   // Store controls
   input  wire logic load_start,
   input  wire logic cksum_good,
   input  wire logic [7:0] ref_half,
   // Far side lines
   output logic      load_done,
   output logic      load_cksum_ok,
   output logic      ref_clk
);
   int cnt = 0;
   int rc  = 0;
   initial begin
      load_done     = 1'b0;
      load_cksum_ok = 1'b0;
      ref_clk       = 1'b0;
   end
   // ----------------------------------------
   // Load answer
   // ----------------------------------------
   // done with checksum
   always @(negedge clk) begin
      load_done <= (cnt == 1);
      if (cnt == 1) begin
         load_cksum_ok <= cksum_good;
      end else if (load_done) begin
         // Stale value is not held after the pulse
         load_cksum_ok <= ~load_cksum_ok;
      end
      cnt <= load_start ? 4 : (cnt > 0 ? cnt - 1 : 0);
   end
   // ----------------------------------------
   // Reference clock
   // ----------------------------------------
   // selectable frequency
   always @(negedge clk) begin
      if (ref_half == 0) begin
         ref_clk <= 1'b0;
      end else if (rc + 1 >= ref_half) begin
         rc      <= 0;
         ref_clk <= ~ref_clk;
      end else begin
         rc <= rc + 1;
      end
   end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Register and output checks of the hub config/status block
// Assumes: Strobes one cycle wide, inputs driven at the falling edge
// Notes  : Frequency checks wait past two measurement windows
`timescale 1ns/1ps
`default_nettype none
module testbench
   import hgc_pkg::*;
;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_stb = 1'b0;
   logic       rd_stb = 1'b0;
   logic [7:0] rdata;
   logic [3:0] lock = 4'h0;
   logic [3:0] assign_p = 4'h0;
   logic       ref_clk, ld_done, ld_ok, ld_start;
   logic       i2c_en, par_en, ref_pres;
   logic [1:0] tx_state;
   logic       ck_good = 1'b1;
   logic [7:0] ref_half = 8'h03;
   int         err_count = 0;
   int         n_compared = 0;
   logic [7:0] v, c;

   always #2.5 clk = ~clk;

   hgc_top hgc_top_i (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr),
      .REG_WR_STB(wr_stb), .REG_WDATA(wdata), .REG_RD_STB(rd_stb),
      .REG_RDATA(rdata), .RX_LOCK(lock), .RX_PORT_ASSIGN(assign_p),
      .REFERENCE_CLOCK_INPUT(ref_clk), .CFG_LOAD_DONE(ld_done),
      .CFG_LOAD_CKSUM_OK(ld_ok), .CFG_LOAD_START(ld_start),
      .I2C_CTRL_EN(i2c_en), .TX_OUT_STATE(tx_state),
      .PARITY_CHECK_EN(par_en), .REF_CLOCK_PRESENT(ref_pres));
   hgc_store_model hgc_store_model_i (.clk(clk), .load_start(ld_start),
      .cksum_good(ck_good), .ref_half(ref_half), .load_done(ld_done),
      .load_cksum_ok(ld_ok), .ref_clk(ref_clk));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr   = a;
      wdata  = d;
      wr_stb = 1'b1;
      @(negedge clk);
      wr_stb = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr   = a;
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      d      = rdata;
   endtask
   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   function automatic logic [1:0] tx_exp(input logic [7:0] g,
                                         input logic lk);
      if (g[BIT_IDLE_SEL] && !g[BIT_DRIVE_EN]) return TX_HIZ;
      if (!lk && !g[BIT_LOCKLESS_SEL]) return TX_HIZ;
      if (!lk && !g[BIT_IDLE_SEL]) return TX_HS0;
      if (!lk) return TX_LP11;
      return TX_NORMAL;
   endfunction
   task automatic wait_init();
      for (int n = 0; n < 50; n++) begin
         rd(ADDR_DEV_STATUS, v);
         if (v[BIT_INIT_DONE] === 1'b1) return;
      end
      chk("init done wait", {7'h0, v[BIT_INIT_DONE]}, 8'h01);
      print_verdict();
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      rd(ADDR_GEN_CFG, v);
      chk("cfg reset", v, 8'h1E);
      chk("i2c reset", {7'h0, i2c_en}, 8'h00);
      chk("tx reset", {6'h0, tx_state}, {6'h0, TX_LP11});
      chk("parity reset", {7'h0, par_en}, 8'h01);
      wait_init();
      repeat (420) @(negedge clk);
      rd(ADDR_DEV_STATUS, v);
      chk("status valid ref", v, 8'hD0);
      chk("ref present", {7'h0, ref_pres}, 8'h01);
      ref_half = 8'h0A;
      repeat (420) @(negedge clk);
      rd(ADDR_DEV_STATUS, v);
      chk("status slow ref", v, 8'hC0);
      chk("ref absent", {7'h0, ref_pres}, 8'h00);
      wr(ADDR_GEN_CFG, 8'h1F);
      chk("ref forced", {7'h0, ref_pres}, 8'h01);
      wr(ADDR_GEN_CFG, 8'h20);
      chk("i2c on", {7'h0, i2c_en}, 8'h01);
      chk("parity off", {7'h0, par_en}, 8'h00);
      ref_half = 8'h01;
      repeat (420) @(negedge clk);
      rd(ADDR_DEV_STATUS, v);
      chk("status fast ref", v, 8'hC0);
      // Reload with a bad checksum
      ck_good = 1'b0;
      wr(ADDR_RESET_CTL, 8'h04);
      @(negedge clk);
      chk("load start", {7'h0, ld_start}, 8'h01);
      rd(ADDR_DEV_STATUS, v);
      chk("init cleared", v, 8'h00);
      chk("load start end", {7'h0, ld_start}, 8'h00);
      wait_init();
      chk("reload status", v, 8'h40);
      rd(ADDR_RESET_CTL, v);
      chk("reload self clear", v, 8'h00);
      // Read-only, reserved and unmapped places
      wr(ADDR_DEV_STATUS, 8'hFF);
      rd(ADDR_DEV_STATUS, v);
      chk("status write", v, 8'h40);
      wr(ADDR_REV_ID, 8'h00);
      rd(ADDR_REV_ID, v);
      chk("revision", v, {SILICON_REVISION, MASK_REVISION});
      rd(8'h7F, v);
      chk("unmapped", v, 8'h00);
      // Every mode bit combination, with and without lock
      for (int i = 0; i < 16; i++) begin
         c        = {2'b11, 1'b0, i[2:0], 2'b10};
         lock     = 4'b0101;
         assign_p = i[3] ? 4'b0100 : 4'b1010;
         wr(ADDR_GEN_CFG, c);
         chk("tx state", {6'h0, tx_state},
             {6'h0, tx_exp(c, i[3])});
         rd(ADDR_GEN_CFG, v);
         chk("cfg readback", v, c & 8'h3F);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
